// >>> logic/ipcb_defs.svh
// offsets, field positions and reset values for the priority configuration bank
`ifndef IPCB_DEFS_SVH
`define IPCB_DEFS_SVH
// ==========================================================
// register byte offsets
`define IPCB_OFF_CFG18 12'h000
`define IPCB_OFF_CFG19 12'h004
`define IPCB_OFF_CFG20 12'h008
`define IPCB_OFF_CFG21 12'h00C
`define IPCB_OFF_CFG22 12'h010
`define IPCB_OFF_CFG23 12'h014
`define IPCB_ADDR_W 12
`define IPCB_NREG 6
// ==========================================================
// implemented-bit masks per register
`define IPCB_MASK_CFG18 16'h0077
`define IPCB_MASK_CFG19 16'h0770
`define IPCB_MASK_CFG20 16'h7770
`define IPCB_MASK_CFG21 16'h7777
`define IPCB_MASK_CFG22 16'h7777
`define IPCB_MASK_CFG23 16'h7777
// ==========================================================
// reset: each field 100
`define IPCB_RST_ALL 16'h4444
`define IPCB_LVL_RST 3'h4
`define IPCB_EN_RST 19'h7_FFFF
// ==========================================================
// field low-bit positions
`define IPCB_POS_F0 0
`define IPCB_POS_F1 4
`define IPCB_POS_F2 8
`define IPCB_POS_F3 12
// ==========================================================
// priority codes
`define IPCB_LVL_OFF 3'h0
`define IPCB_LVL_MIN 3'h1
`define IPCB_LVL_MAX 3'h7
`endif

// >>> logic/ipcb_pkg.sv
// types for the priority configuration bank
package ipcb_pkg;
  typedef logic [2:0] ipcb_level_t;
  typedef logic [15:0] ipcb_word_t;
  typedef enum logic [1:0]
  {
    IPCB_IDLE = 2'b00,
    IPCB_ACCESS = 2'b01
  } ipcb_phase_t;
endpackage : ipcb_pkg

// >>> logic/ipcb_regif.sv
// register write/read carrier between bus slave and register bank
`timescale 1ns/1ps
interface ipcb_regif;
  logic wr_en;
  logic [2:0] idx;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport slave_side (output wr_en, output idx, output wdata, input rdata);
  modport bank_side (input wr_en, input idx, input wdata, output rdata);
endinterface : ipcb_regif

// >>> logic/ipcb_apb_slave.sv
// apb slave front end of the priority bank
`timescale 1ns/1ps
`include "ipcb_defs.svh"
module ipcb_apb_slave
  import ipcb_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bank side
  ipcb_regif.slave_side rif
);
  // ==========================================================
  // address decode
  function automatic logic [3:0] dec(input logic [11:0] a);
    logic [3:0] r;
    r = 4'h8;
    if (a[1:0] == 2'b00 && a[11:2] < 10'(`IPCB_NREG))
      r = {1'b0, a[4:2]};
    return r;
  endfunction : dec

  logic [3:0] d;
  logic setup;
  assign d = dec(paddr);
  assign setup = psel && !penable;
  assign rif.idx = d[2:0];
  assign rif.wdata = pwdata[15:0];
  // write takes effect at the access edge, which ends the access phase one cycle after setup
  assign rif.wr_en = psel && penable && pready && pwrite && !d[3];

  // ==========================================================
  // one wait-free access phase: ready registered from setup
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= setup && d[3];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite && !d[3])
      prdata <= {16'h0000, rif.rdata};
    else if (setup)
      prdata <= 32'h0000_0000;
endmodule : ipcb_apb_slave

// >>> logic/ipcb_bank.sv
// priority configuration bank top: apb registers and per-source priority outputs
`timescale 1ns/1ps
`include "ipcb_defs.svh"
module ipcb_bank
  import ipcb_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // priority levels
  output logic [2:0] volt_detect_priority,
  output logic [2:0] capcomp7_priority,
  output logic [2:0] charge_time_priority,
  output logic [2:0] dac_priority,
  output logic [2:0] uart3_err_priority,
  output logic [2:0] uart3_rx_priority,
  output logic [2:0] uart3_tx_priority,
  output logic [2:0] i2c1_collision_priority,
  output logic [2:0] i2c2_collision_priority,
  output logic [2:0] usb_priority,
  output logic [2:0] uart4_err_priority,
  output logic [2:0] uart4_rx_priority,
  output logic [2:0] uart4_tx_priority,
  output logic [2:0] spi3_general_priority,
  output logic [2:0] spi3_tx_priority,
  output logic [2:0] spi4_general_priority,
  output logic [2:0] spi4_tx_priority,
  output logic [2:0] capcomp3_priority,
  output logic [2:0] capcomp4_priority,
  // source enables: level nonzero
  output logic [18:0] source_enable
);
  ipcb_regif rif ();

  ipcb_apb_slave u_apb
  (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif)
  );

  // ==========================================================
  // storage
  ipcb_word_t prio_cfg_18_q;
  ipcb_word_t prio_cfg_19_q;
  ipcb_word_t prio_cfg_20_q;
  ipcb_word_t prio_cfg_21_q;
  ipcb_word_t prio_cfg_22_q;
  ipcb_word_t prio_cfg_23_q;

  function automatic ipcb_word_t reg_mask(input logic [2:0] i);
    ipcb_word_t m;
    m = 16'h0000;
    case (i)
      3'd0: m = `IPCB_MASK_CFG18;
      3'd1: m = `IPCB_MASK_CFG19;
      3'd2: m = `IPCB_MASK_CFG20;
      3'd3: m = `IPCB_MASK_CFG21;
      3'd4: m = `IPCB_MASK_CFG22;
      3'd5: m = `IPCB_MASK_CFG23;
      default: m = 16'h0000;
    endcase
    return m;
  endfunction : reg_mask

  function automatic ipcb_level_t fld(input ipcb_word_t w, input int pos);
    return w[pos +: 3];
  endfunction : fld

  function automatic logic wr_hit(input logic en, input logic [2:0] sel, input logic [2:0] i);
    return en && sel == i;
  endfunction : wr_hit

  // ==========================================================
  // register writes; unimplemented bits never stored
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prio_cfg_18_q <= `IPCB_RST_ALL & `IPCB_MASK_CFG18;
    else if (wr_hit(rif.wr_en, rif.idx, 3'd0))
      prio_cfg_18_q <= rif.wdata & reg_mask(3'd0);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prio_cfg_19_q <= `IPCB_RST_ALL & `IPCB_MASK_CFG19;
    else if (wr_hit(rif.wr_en, rif.idx, 3'd1))
      prio_cfg_19_q <= rif.wdata & reg_mask(3'd1);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prio_cfg_20_q <= `IPCB_RST_ALL & `IPCB_MASK_CFG20;
    else if (wr_hit(rif.wr_en, rif.idx, 3'd2))
      prio_cfg_20_q <= rif.wdata & reg_mask(3'd2);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prio_cfg_21_q <= `IPCB_RST_ALL & `IPCB_MASK_CFG21;
    else if (wr_hit(rif.wr_en, rif.idx, 3'd3))
      prio_cfg_21_q <= rif.wdata & reg_mask(3'd3);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prio_cfg_22_q <= `IPCB_RST_ALL & `IPCB_MASK_CFG22;
    else if (wr_hit(rif.wr_en, rif.idx, 3'd4))
      prio_cfg_22_q <= rif.wdata & reg_mask(3'd4);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prio_cfg_23_q <= `IPCB_RST_ALL & `IPCB_MASK_CFG23;
    else if (wr_hit(rif.wr_en, rif.idx, 3'd5))
      prio_cfg_23_q <= rif.wdata & reg_mask(3'd5);

  // ==========================================================
  // read mux; unmapped index reads zero
  ipcb_word_t rd_word;

  always_comb
  begin
    rd_word = 16'h0000;
    case (rif.idx)
      3'd0: rd_word = prio_cfg_18_q;
      3'd1: rd_word = prio_cfg_19_q;
      3'd2: rd_word = prio_cfg_20_q;
      3'd3: rd_word = prio_cfg_21_q;
      3'd4: rd_word = prio_cfg_22_q;
      3'd5: rd_word = prio_cfg_23_q;
      default: rd_word = 16'h0000;
    endcase
  end

  assign rif.rdata = rd_word;

  // ==========================================================
  // field decode shared by level and enable flops
  ipcb_level_t volt_detect_d;
  ipcb_level_t capcomp7_d;
  ipcb_level_t charge_time_d;
  ipcb_level_t dac_d;
  ipcb_level_t uart3_err_d;
  ipcb_level_t uart3_rx_d;
  ipcb_level_t uart3_tx_d;
  ipcb_level_t i2c1_collision_d;
  ipcb_level_t i2c2_collision_d;
  ipcb_level_t usb_d;
  ipcb_level_t uart4_err_d;
  ipcb_level_t uart4_rx_d;
  ipcb_level_t uart4_tx_d;
  ipcb_level_t spi3_general_d;
  ipcb_level_t spi3_tx_d;
  ipcb_level_t spi4_general_d;
  ipcb_level_t spi4_tx_d;
  ipcb_level_t capcomp3_d;
  ipcb_level_t capcomp4_d;

  assign volt_detect_d = fld(prio_cfg_18_q, `IPCB_POS_F0);
  assign capcomp7_d = fld(prio_cfg_18_q, `IPCB_POS_F1);
  assign charge_time_d = fld(prio_cfg_19_q, `IPCB_POS_F1);
  assign dac_d = fld(prio_cfg_19_q, `IPCB_POS_F2);
  assign uart3_err_d = fld(prio_cfg_20_q, `IPCB_POS_F1);
  assign uart3_rx_d = fld(prio_cfg_20_q, `IPCB_POS_F2);
  assign uart3_tx_d = fld(prio_cfg_20_q, `IPCB_POS_F3);
  assign i2c1_collision_d = fld(prio_cfg_21_q, `IPCB_POS_F0);
  assign i2c2_collision_d = fld(prio_cfg_21_q, `IPCB_POS_F1);
  assign usb_d = fld(prio_cfg_21_q, `IPCB_POS_F2);
  assign uart4_err_d = fld(prio_cfg_21_q, `IPCB_POS_F3);
  assign uart4_rx_d = fld(prio_cfg_22_q, `IPCB_POS_F0);
  assign uart4_tx_d = fld(prio_cfg_22_q, `IPCB_POS_F1);
  assign spi3_general_d = fld(prio_cfg_22_q, `IPCB_POS_F2);
  assign spi3_tx_d = fld(prio_cfg_22_q, `IPCB_POS_F3);
  assign spi4_general_d = fld(prio_cfg_23_q, `IPCB_POS_F0);
  assign spi4_tx_d = fld(prio_cfg_23_q, `IPCB_POS_F1);
  assign capcomp3_d = fld(prio_cfg_23_q, `IPCB_POS_F2);
  assign capcomp4_d = fld(prio_cfg_23_q, `IPCB_POS_F3);

  // ==========================================================
  // registered level outputs; level equals code, 0 disables
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      volt_detect_priority <= `IPCB_LVL_RST;
    else
      volt_detect_priority <= volt_detect_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      capcomp7_priority <= `IPCB_LVL_RST;
    else
      capcomp7_priority <= capcomp7_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      charge_time_priority <= `IPCB_LVL_RST;
    else
      charge_time_priority <= charge_time_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      dac_priority <= `IPCB_LVL_RST;
    else
      dac_priority <= dac_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      uart3_err_priority <= `IPCB_LVL_RST;
    else
      uart3_err_priority <= uart3_err_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      uart3_rx_priority <= `IPCB_LVL_RST;
    else
      uart3_rx_priority <= uart3_rx_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      uart3_tx_priority <= `IPCB_LVL_RST;
    else
      uart3_tx_priority <= uart3_tx_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      i2c1_collision_priority <= `IPCB_LVL_RST;
    else
      i2c1_collision_priority <= i2c1_collision_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      i2c2_collision_priority <= `IPCB_LVL_RST;
    else
      i2c2_collision_priority <= i2c2_collision_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      usb_priority <= `IPCB_LVL_RST;
    else
      usb_priority <= usb_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      uart4_err_priority <= `IPCB_LVL_RST;
    else
      uart4_err_priority <= uart4_err_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      uart4_rx_priority <= `IPCB_LVL_RST;
    else
      uart4_rx_priority <= uart4_rx_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      uart4_tx_priority <= `IPCB_LVL_RST;
    else
      uart4_tx_priority <= uart4_tx_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      spi3_general_priority <= `IPCB_LVL_RST;
    else
      spi3_general_priority <= spi3_general_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      spi3_tx_priority <= `IPCB_LVL_RST;
    else
      spi3_tx_priority <= spi3_tx_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      spi4_general_priority <= `IPCB_LVL_RST;
    else
      spi4_general_priority <= spi4_general_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      spi4_tx_priority <= `IPCB_LVL_RST;
    else
      spi4_tx_priority <= spi4_tx_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      capcomp3_priority <= `IPCB_LVL_RST;
    else
      capcomp3_priority <= capcomp3_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      capcomp4_priority <= `IPCB_LVL_RST;
    else
      capcomp4_priority <= capcomp4_d;

  // ==========================================================
  // enable: 000 disables, 001..111 active levels 1..7
  function automatic logic active(input ipcb_level_t l);
    return l != `IPCB_LVL_OFF;
  endfunction : active

  logic [18:0] enable_d;

  always_comb
  begin
    enable_d = 19'h0_0000;
    enable_d[0] = active(volt_detect_d);
    enable_d[1] = active(capcomp7_d);
    enable_d[2] = active(charge_time_d);
    enable_d[3] = active(dac_d);
    enable_d[4] = active(uart3_err_d);
    enable_d[5] = active(uart3_rx_d);
    enable_d[6] = active(uart3_tx_d);
    enable_d[7] = active(i2c1_collision_d);
    enable_d[8] = active(i2c2_collision_d);
    enable_d[9] = active(usb_d);
    enable_d[10] = active(uart4_err_d);
    enable_d[11] = active(uart4_rx_d);
    enable_d[12] = active(uart4_tx_d);
    enable_d[13] = active(spi3_general_d);
    enable_d[14] = active(spi3_tx_d);
    enable_d[15] = active(spi4_general_d);
    enable_d[16] = active(spi4_tx_d);
    enable_d[17] = active(capcomp3_d);
    enable_d[18] = active(capcomp4_d);
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      source_enable <= `IPCB_EN_RST;
    else
      source_enable <= enable_d;
endmodule : ipcb_bank

// >>> sim/ipcb_chk.sv
// port checker for the priority bank
`timescale 1ns/1ps
module ipcb_chk
(
  // apb
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // levels
  input wire logic [2:0] volt_detect_priority, usb_priority,
  input wire logic [18:0] source_enable
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire rd = pready && !pwrite && !pslverr;
  wire wr = pready && pwrite && !pslverr;
  wire [2:0] w_lo = pwdata[2:0];
  wire [2:0] w_mid = pwdata[10:8];
  // ==========================================================
  // assertions
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_range: assert property (setup && paddr >= 12'h018 |=> pslverr)
    else $error("unmapped address accepted");
  a_err_align: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned address accepted");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_first_unused: assert property (rd && paddr == 12'h000 |-> prdata[15:7] == 9'h000 && !prdata[3])
    else $error("unused bits read nonzero");
  a_volt_follow: assert property (wr && paddr == 12'h000 |-> ##2 volt_detect_priority == $past(w_lo, 2))
    else $error("voltage level not written");
  a_usb_follow: assert property (wr && paddr == 12'h00C |-> ##2 usb_priority == $past(w_mid, 2))
    else $error("usb level not written");
  a_off_disable: assert property (volt_detect_priority == 3'h0 |-> ##[0:1] !source_enable[0])
    else $error("zero level left enabled");
  c_err: cover property (pready && pslverr);
  c_off: cover property (usb_priority == 3'h0);
  c_max: cover property (volt_detect_priority == 3'h7);
endmodule : ipcb_chk
bind ipcb_bank ipcb_chk u_chk (.*);

// >>> sim/tb_ipcb_bank.sv
// self-checking bench for the priority bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin tests_run++; if ((got) !== (ex)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_ipcb_bank;
  import ipcb_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [2:0] volt_detect_priority, capcomp7_priority, charge_time_priority, dac_priority;
  logic [2:0] uart3_err_priority, uart3_rx_priority, uart3_tx_priority, usb_priority;
  logic [2:0] i2c1_collision_priority, i2c2_collision_priority, uart4_err_priority;
  logic [2:0] uart4_rx_priority, uart4_tx_priority, spi3_general_priority, spi3_tx_priority;
  logic [2:0] spi4_general_priority, spi4_tx_priority, capcomp3_priority, capcomp4_priority;
  logic [18:0] source_enable;
  ipcb_word_t rdv;
  int n_fail = 0, tests_run = 0;
  localparam ipcb_word_t MSK [6] = '{16'h0077, 16'h0770, 16'h7770, 16'h7777, 16'h7777, 16'h7777};
  ipcb_bank uut (.*);
  always #25 pclk = ~pclk;
  // ==========================================================
  // bus cycles
  task automatic apb(input logic w, input logic [11:0] a, input ipcb_word_t d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'hFFFF, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdv = prdata[15:0];
    err = pslverr;
    `CHK("hi", 16'h0000, prdata[31:16])
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input ipcb_word_t ex);
    apb(1'b0, a, 16'h0000);
    `CHK("rd", ex, rdv)
  endtask : rchk
  // ==========================================================
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 6; i++)
      rchk(12'(4 * i), 16'h4444 & MSK[i]);
    `CHK("en", 19'h7_FFFF, source_enable)
    `CHK("lv", 3'h4, spi4_tx_priority)
  endtask : t_reset
  task automatic t_fields;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 12'(4 * i), 16'h9ABC);
      rchk(12'(4 * i), 16'h9ABC & MSK[i]);
    end
    `CHK("r18", 6'h1C, {capcomp7_priority, volt_detect_priority})
    `CHK("r19", 6'h13, {dac_priority, charge_time_priority})
    `CHK("r20", 9'h053, {uart3_tx_priority, uart3_rx_priority, uart3_err_priority})
    `CHK("r21", 12'h29C, {uart4_err_priority, usb_priority, i2c2_collision_priority,
      i2c1_collision_priority})
    `CHK("r22", 12'h29C, {spi3_tx_priority, spi3_general_priority, uart4_tx_priority,
      uart4_rx_priority})
    `CHK("r23", 12'h29C, {capcomp4_priority, capcomp3_priority, spi4_tx_priority,
      spi4_general_priority})
  endtask : t_fields
  task automatic t_codes;
    ipcb_word_t w;
    for (int c = 0; c < 8; c++)
    begin
      w = {4{1'b0, 3'(c)}};
      apb(1'b1, 12'h00C, w);
      rchk(12'h00C, w);
      `CHK("usb", 3'(c), usb_priority)
      `CHK("on", 1'(c != 0), source_enable[9])
      `CHK("mid", {4{1'(c != 0)}}, source_enable[10:7])
      apb(1'b1, 12'h000, w);
      rchk(12'h000, w & MSK[0]);
      `CHK("volt", 3'(c), volt_detect_priority)
      `CHK("lo", {2{1'(c != 0)}}, source_enable[1:0])
    end
  endtask : t_codes
  task automatic t_bad;
    apb(1'b1, 12'h018, 16'h0000);
    `CHK("e18", 1'b1, err)
    apb(1'b1, 12'h002, 16'h0000);
    `CHK("e02", 1'b1, err)
    rchk(12'h000, 16'h0077);
  endtask : t_bad
  task automatic give_verdict;
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_fields;
    t_codes;
    t_bad;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    give_verdict;
  end
  initial
  begin
    #200000;
    n_fail++;
    give_verdict;
  end
endmodule : tb_ipcb_bank
